// *** rtl/power_mode_map.vh ***
// Register offsets, field positions, reset values and timing of the power mode controller.
`ifndef POWER_MODE_MAP_VH
`define POWER_MODE_MAP_VH

// ==========================================================================
// Register byte offsets
`define PMC_OFS_CTRL 8'h00
`define PMC_OFS_STATUS 8'h04
`define PMC_OFS_PCFG 8'h08
`define PMC_OFS_PRUN 8'h0c
`define PMC_OFS_SLOWEN 8'h10
`define PMC_OFS_WAKEEN 8'h14
`define PMC_OFS_ISTAT 8'h18
`define PMC_OFS_IMASK 8'h1c

// ==========================================================================
// Control register fields
`define PMC_CTRL_DEEP 0
`define PMC_CTRL_AFTER 1
`define PMC_CTRL_WAKECLK 2
`define PMC_CTRL_CLKEXT 3
`define PMC_CTRL_INTEN 4
`define PMC_CTRL_EXTEN 5
`define PMC_CTRL_W 6
`define PMC_CTRL_RST 6'h10

// ==========================================================================
// Interrupt status fields and other reset values
`define PMC_EV_SLEEP 0
`define PMC_EV_DEEP 1
`define PMC_EV_WAKE 2
`define PMC_EV_W 3
`define PMC_PCLK_RST 16'h0003
`define PMC_RESP_OKAY 2'b00
`define PMC_RESP_SLVERR 2'b10

// ==========================================================================
// Fast oscillator settle time after wake, in ns, and the clock period
`define PMC_SETTLE_NS 160
`define PMC_CLK_NS 10

`endif

// *** rtl/sync_2ff.v ***
// Two flip-flop synchroniser with asynchronous reset to zero.
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
   parameter WIDTH = 1
) (
   input wire clk,
   input wire rstN,
   input wire [WIDTH-1:0] d,
   output reg [WIDTH-1:0] q
);

   reg [WIDTH-1:0] meta_q;

   // The first stage feeds only the second stage.
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         meta_q <= {WIDTH{1'b0}};
         q <= {WIDTH{1'b0}};
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule
`default_nettype wire

// *** rtl/settle_timer.v ***
// Counts an oscillator's ready level for a settle period and flags done.
`timescale 1ns/1ps
`default_nettype none

module settle_timer #(
   parameter CYCLES = 16,
   parameter CW = 8
) (
   input wire clk,
   input wire rstN,
   input wire run,
   input wire ready,
   output reg done
);

   localparam [31:0] LAST_W = CYCLES - 1;
   localparam [CW-1:0] LAST = LAST_W[CW-1:0];
   reg [CW-1:0] count_q;

   // Any drop of ready restarts the count, so a glitchy start is not trusted.
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         count_q <= {CW{1'b0}};
         done <= 1'b0;
      end else if (!run || !ready) begin
         count_q <= {CW{1'b0}};
         done <= 1'b0;
      end else if (count_q == LAST) begin
         done <= 1'b1;
      end else begin
         count_q <= count_q + 1'b1;
      end
   end

endmodule
`default_nettype wire

// *** rtl/power_mode_controller.v ***
// Operating-mode controller: Active, Sleep and DeepSleep with clock gating.
//
// Functional notes
// - Power-up enters Active; only three modes
// - Wait request enters Sleep or DeepSleep
// - Handler return sleeps when after-handler set
// - Sleep halts processor only
// - DeepSleep stops fast oscillators, keeps slow
// - Hardware interrupt wakes back to Active
// - Supply supervisor resets in every mode
// - Peripheral clocks off after reset, except two
// - Config clock off discards writes silently
// - Operating clock off stops peripheral function
// - Wake clock select forces internal fast clock on wake from DeepSleep
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_map.vh"

module power_mode_controller #(
   parameter NPERIPH = 16,
   parameter NIRQ = 32
) (
   input wire clk,
   input wire reset_n,
   input wire coreSupplyOk,
   input wire analogSupplyOk,
   input wire awvalid,
   output reg awready,
   input wire [7:0] awaddr,
   input wire wvalid,
   output reg wready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   output reg bvalid,
   input wire bready,
   output reg [1:0] bresp,
   input wire arvalid,
   output reg arready,
   input wire [7:0] araddr,
   output reg rvalid,
   input wire rready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   input wire waitInterruptRequest,
   input wire handlerReturn,
   input wire [NIRQ-1:0] irqLines,
   input wire intFastReady,
   input wire extFastReady,
   output reg sysReset_n,
   output reg cpuClkEn,
   output reg internalFastOscEn,
   output reg externalFastOscEn,
   output reg sysClkExternal,
   output reg [3:0] slowOscEn,
   output reg [NPERIPH-1:0] periphCfgClkEn,
   output reg [NPERIPH-1:0] periphRunClkEn,
   output reg modeSleep,
   output reg modeDeep,
   output reg irq
);

   // ========================================================================
   // Constants and state codes

   localparam integer SETTLE_CYC =
      (`PMC_SETTLE_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS;
   localparam [3:0] ST_ACTIVE = 4'h1;
   localparam [3:0] ST_SLEEP = 4'h2;
   localparam [3:0] ST_DEEP = 4'h4;
   localparam [3:0] ST_WAKE = 4'h8;

   // ========================================================================
   // Reset and input synchronisation

   wire rawReset_n;
   wire rstN;
   wire [NIRQ-1:0] irqSync;
   wire [1:0] readySync;
   wire settled;

   // supply supervisor reset
   // A low on either supply holds everything in reset whatever the mode.
   assign rawReset_n = reset_n & coreSupplyOk & analogSupplyOk;

   sync_2ff #(.WIDTH(1)) u_rst_sync (
      .clk(clk),
      .rstN(rawReset_n),
      .d(1'b1),
      .q(rstN)
   );

   // Interrupt lines may come from pins, so they are synchronised first.
   sync_2ff #(.WIDTH(NIRQ)) u_irq_sync (
      .clk(clk),
      .rstN(rstN),
      .d(irqLines),
      .q(irqSync)
   );

   sync_2ff #(.WIDTH(2)) u_rdy_sync (
      .clk(clk),
      .rstN(rstN),
      .d({extFastReady, intFastReady}),
      .q(readySync)
   );

   // ========================================================================
   // Registers

   reg [`PMC_CTRL_W-1:0] ctrl_q;
   reg [NPERIPH-1:0] pcfg_q;
   reg [NPERIPH-1:0] prun_q;
   reg [3:0] slowEn_q;
   reg [NIRQ-1:0] wakeEn_q;
   reg [`PMC_EV_W-1:0] istat_q;
   reg [`PMC_EV_W-1:0] imask_q;
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg awHeld_q;
   reg wHeld_q;
   reg [7:0] awAddr_q;
   reg [31:0] wData_q;
   reg [3:0] wStrb_q;

   wire deepSel = ctrl_q[`PMC_CTRL_DEEP];
   wire afterHandler = ctrl_q[`PMC_CTRL_AFTER];
   wire wakeClkSel = ctrl_q[`PMC_CTRL_WAKECLK];
   wire wakeHit;
   wire sleepReq;
   wire selReady;
   wire doWrite;
   wire doRead;
   wire wrMapped;
   wire rdMapped;

   // ========================================================================
   // Mode sequencing

   // enabled wake sources only
   // Lines not enabled as wake sources are ignored while asleep.
   assign wakeHit = |(irqSync & wakeEn_q);

   // sleep on handler return
   // Both entry paths share one request; the deep bit picks the mode.
   assign sleepReq = waitInterruptRequest | (handlerReturn & afterHandler);

   assign selReady = ctrl_q[`PMC_CTRL_CLKEXT] ? readySync[1] : readySync[0];

   // fast oscillator settle
   // The processor stays halted until the chosen source reads stable.
   settle_timer #(.CYCLES(SETTLE_CYC), .CW(8)) u_settle (
      .clk(clk),
      .rstN(rstN),
      .run(state_q == ST_WAKE),
      .ready(selReady),
      .done(settled)
   );

   // Next mode from the present one and this cycle's events.
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_ACTIVE: begin
            if (sleepReq) begin
               state_d = deepSel ? ST_DEEP : ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wakeHit) begin
               state_d = ST_ACTIVE;
            end
         end
         ST_DEEP: begin
            if (wakeHit) begin
               state_d = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (settled) begin
               state_d = ST_ACTIVE;
            end
         end
         default: begin
            state_d = ST_ACTIVE;
         end
      endcase
   end

   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_q <= ST_ACTIVE;
      end else begin
         state_q <= state_d;
      end
   end

   // Mode outputs are taken from the next state so they move with it.
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         cpuClkEn <= 1'b1;
         modeSleep <= 1'b0;
         modeDeep <= 1'b0;
         internalFastOscEn <= 1'b1;
         externalFastOscEn <= 1'b0;
         sysClkExternal <= 1'b0;
         slowOscEn <= 4'h0;
         sysReset_n <= 1'b0;
      end else begin
         sysReset_n <= 1'b1;
         cpuClkEn <= (state_d == ST_ACTIVE);
         modeSleep <= (state_d == ST_SLEEP);
         modeDeep <= (state_d == ST_DEEP) | (state_d == ST_WAKE);
         internalFastOscEn <= ctrl_q[`PMC_CTRL_INTEN] &
            (state_d != ST_DEEP);
         externalFastOscEn <= ctrl_q[`PMC_CTRL_EXTEN] &
            (state_d != ST_DEEP);
         sysClkExternal <= ctrl_q[`PMC_CTRL_CLKEXT];
         // Slow oscillators follow software alone, whatever the mode.
         slowOscEn <= slowEn_q;
      end
   end

   // operating clock gates function
   // The operating enable stands alone, so a configured peripheral with
   // its operating clock off still does nothing.
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         periphCfgClkEn <= `PMC_PCLK_RST;
         periphRunClkEn <= `PMC_PCLK_RST;
      end else begin
         // writes lost without fault
         // With its configuration clock off a peripheral never sees the
         // write, and nothing here reports an error for it.
         periphCfgClkEn <= pcfg_q;
         periphRunClkEn <= prun_q;
      end
   end

   // ========================================================================
   // AXI4-Lite write channel

   assign doWrite = awHeld_q & wHeld_q & ~bvalid;
   assign wrMapped = (awAddr_q[1:0] == 2'b00) &&
      (awAddr_q[7:2] <= (`PMC_OFS_IMASK >> 2));

   // Address and data are taken in either order; the answer needs both.
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         awready <= 1'b0;
         wready <= 1'b0;
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q <= 32'h00000000;
         wStrb_q <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `PMC_RESP_OKAY;
      end else begin
         awready <= ~awHeld_q & ~(awvalid & awready) & ~bvalid;
         wready <= ~wHeld_q & ~(wvalid & wready) & ~bvalid;
         if (awvalid && awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= awaddr;
         end
         if (wvalid && wready) begin
            wHeld_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
         end
         if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= wrMapped ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
         end
      end
   end

   // Byte lanes merge new data into an old value under the strobes.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
         end
      end
   endfunction

   // ========================================================================
   // Register writes and hardware updates

   wire [31:0] ctrlWide = {{(32-`PMC_CTRL_W){1'b0}}, ctrl_q};
   wire [31:0] pcfgWide = {{(32-NPERIPH){1'b0}}, pcfg_q};
   wire [31:0] prunWide = {{(32-NPERIPH){1'b0}}, prun_q};
   wire [31:0] slowWide = {28'h0000000, slowEn_q};
   wire [31:0] maskWide = {29'h0, imask_q};
   wire [31:0] ctrlNew = merge(ctrlWide, wData_q, wStrb_q);
   wire [31:0] pcfgNew = merge(pcfgWide, wData_q, wStrb_q);
   wire [31:0] prunNew = merge(prunWide, wData_q, wStrb_q);
   wire [31:0] slowNew = merge(slowWide, wData_q, wStrb_q);
   wire [31:0] wakeNew = merge(wakeEn_q, wData_q, wStrb_q);
   wire [31:0] maskNew = merge(maskWide, wData_q, wStrb_q);
   wire wakeFromDeep = (state_q == ST_DEEP) & wakeHit;

   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ctrl_q <= `PMC_CTRL_RST;
         pcfg_q <= `PMC_PCLK_RST;
         prun_q <= `PMC_PCLK_RST;
         slowEn_q <= 4'h0;
         wakeEn_q <= {NIRQ{1'b0}};
         imask_q <= 3'h0;
      end else begin
         if (doWrite) begin
            case (awAddr_q)
               `PMC_OFS_CTRL: ctrl_q <= ctrlNew[`PMC_CTRL_W-1:0];
               `PMC_OFS_PCFG: pcfg_q <= pcfgNew[NPERIPH-1:0];
               `PMC_OFS_PRUN: prun_q <= prunNew[NPERIPH-1:0];
               `PMC_OFS_SLOWEN: slowEn_q <= slowNew[3:0];
               `PMC_OFS_WAKEEN: wakeEn_q <= wakeNew[NIRQ-1:0];
               `PMC_OFS_IMASK: imask_q <= maskNew[`PMC_EV_W-1:0];
               default: begin
               end
            endcase
         end
         // wake onto internal clock
         // Hardware wins over a same-cycle software write here.
         if (wakeFromDeep && wakeClkSel) begin
            ctrl_q[`PMC_CTRL_CLKEXT] <= 1'b0;
            ctrl_q[`PMC_CTRL_INTEN] <= 1'b1;
         end
      end
   end

   // ========================================================================
   // Event flags and interrupt output

   wire [`PMC_EV_W-1:0] evSet;
   wire istatClear;
   wire [`PMC_EV_W-1:0] istatNext;

   assign evSet[`PMC_EV_SLEEP] = (state_q != ST_SLEEP) &
      (state_d == ST_SLEEP);
   assign evSet[`PMC_EV_DEEP] = (state_q != ST_DEEP) &
      (state_d == ST_DEEP);
   assign evSet[`PMC_EV_WAKE] = (state_q != ST_ACTIVE) &
      (state_d == ST_ACTIVE);
   assign istatClear = doRead && (araddr == `PMC_OFS_ISTAT);

   // A read clears the flags, but an event in that same cycle survives.
   assign istatNext = (istatClear ? 3'h0 : istat_q) | evSet;

   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         istat_q <= 3'h0;
         irq <= 1'b0;
      end else begin
         istat_q <= istatNext;
         irq <= |(istatNext & imask_q);
      end
   end

   // ========================================================================
   // AXI4-Lite read channel

   assign doRead = arvalid & arready;
   assign rdMapped = (araddr[1:0] == 2'b00) &&
      (araddr[7:2] <= (`PMC_OFS_IMASK >> 2));

   reg [31:0] rdValue;

   // Status shows the live mode, the halt and the synchronised readies.
   always @* begin
      rdValue = 32'h00000000;
      case (araddr)
         `PMC_OFS_CTRL: rdValue = ctrlWide;
         `PMC_OFS_STATUS: rdValue = {25'h0, readySync, cpuClkEn,
            state_q};
         `PMC_OFS_PCFG: rdValue = pcfgWide;
         `PMC_OFS_PRUN: rdValue = prunWide;
         `PMC_OFS_SLOWEN: rdValue = slowWide;
         `PMC_OFS_WAKEEN: rdValue = wakeEn_q;
         `PMC_OFS_ISTAT: rdValue = {29'h0, istat_q};
         `PMC_OFS_IMASK: rdValue = maskWide;
         default: rdValue = 32'h00000000;
      endcase
   end

   // One read at a time: arready drops until the data are taken.
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `PMC_RESP_OKAY;
      end else begin
         arready <= ~rvalid & ~doRead;
         if (doRead) begin
            rvalid <= 1'b1;
            rdata <= rdValue;
            rresp <= rdMapped ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// *** sim/pmc_assertions.sv ***
// Concurrent checks on the ports of the power mode controller.
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_map.vh"
// ======================================================================
// Checker module
module pmc_checker #(
   parameter NPERIPH = 16,
   parameter NIRQ = 32
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic coreSupplyOk,
   input wire logic analogSupplyOk,
   input wire logic waitInterruptRequest,
   input wire logic [NIRQ-1:0] irqLines,
   input wire logic intFastReady,
   input wire logic extFastReady,
   input wire logic sysReset_n,
   input wire logic cpuClkEn,
   input wire logic internalFastOscEn,
   input wire logic externalFastOscEn,
   input wire logic [3:0] slowOscEn,
   input wire logic [NPERIPH-1:0] periphCfgClkEn,
   input wire logic [NPERIPH-1:0] periphRunClkEn,
   input wire logic modeSleep,
   input wire logic modeDeep
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   property p_modes;
      cpuClkEn == !(modeSleep || modeDeep) && !(modeSleep && modeDeep);
   endproperty
   a_modes: assert property (p_modes)
      else $error("mode outputs inconsistent");
   property p_entry;
      waitInterruptRequest && cpuClkEn && sysReset_n
         |=> !cpuClkEn && (modeSleep != modeDeep);
   endproperty
   a_entry: assert property (p_entry)
      else $error("wait request did not halt the processor");
   property p_deep_osc;
      $rose(modeDeep) |-> !internalFastOscEn && !externalFastOscEn;
   endproperty
   a_deep_osc: assert property (p_deep_osc)
      else $error("fast oscillator left on in deep mode");
   property p_slow_keep;
      $rose(modeSleep || modeDeep)
         |-> $stable(slowOscEn) && $stable(periphRunClkEn);
   endproperty
   a_slow_keep: assert property (p_slow_keep)
      else $error("slow or peripheral clocks changed on entry");
   property p_sleep_hold;
      (modeSleep && irqLines == '0) [*3] |=> modeSleep;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold)
      else $error("left sleep with no interrupt");
   property p_settle;
      (modeDeep && !intFastReady && !extFastReady) [*3]
         |=> modeDeep && !cpuClkEn;
   endproperty
   a_settle: assert property (p_settle)
      else $error("processor released before oscillator ready");
   property p_clk_rst;
      $rose(sysReset_n) |-> periphCfgClkEn == `PMC_PCLK_RST
         && periphRunClkEn == `PMC_PCLK_RST;
   endproperty
   a_clk_rst: assert property (p_clk_rst)
      else $error("peripheral clocks wrong after reset");
   property p_supply;
      !(coreSupplyOk && analogSupplyOk) |-> !sysReset_n && cpuClkEn;
   endproperty
   a_supply: assert property (p_supply)
      else $error("supply loss did not reset the system");
   // Main scenarios reached.
   c_sleep: cover property ($rose(modeSleep));
   c_deep: cover property ($rose(modeDeep));
   c_wake: cover property ($fell(modeDeep));
endmodule

bind power_mode_controller pmc_checker #(.NPERIPH(NPERIPH), .NIRQ(NIRQ))
   u_pmc_checker (.clk, .reset_n, .coreSupplyOk, .analogSupplyOk,
   .waitInterruptRequest, .irqLines, .intFastReady, .extFastReady,
   .sysReset_n, .cpuClkEn, .internalFastOscEn, .externalFastOscEn,
   .slowOscEn, .periphCfgClkEn, .periphRunClkEn, .modeSleep, .modeDeep);
`default_nettype wire

// *** sim/core_model.sv ***
// Behavioural processor core that issues sleep requests.
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// Core model
module core_model (
   input wire logic clk,
   input wire logic cpuClkEn,
   output logic waitInterruptRequest,
   output logic handlerReturn
);
   // Both request pulses idle low from time zero.
   initial begin
      waitInterruptRequest = 1'b0;
      handlerReturn = 1'b0;
   end
   // A halted core executes nothing, so it waits for a running clock.
   task issue(input logic ret);
      begin
         @(posedge clk);
         while (cpuClkEn !== 1'b1) @(posedge clk);
         if (ret) handlerReturn <= 1'b1;
         else waitInterruptRequest <= 1'b1;
         @(posedge clk);
         handlerReturn <= 1'b0;
         waitInterruptRequest <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the power mode controller.
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_map.vh"
// ======================================================================
// Bench top
module tb_top;
   localparam logic [1:0] OK = `PMC_RESP_OKAY;
   localparam logic [1:0] ER = `PMC_RESP_SLVERR;
   localparam int SETTLE = `PMC_SETTLE_NS / `PMC_CLK_NS;
   logic clk = 1'b0, reset_n = 1'b0, coreSupplyOk = 1'b1;
   logic analogSupplyOk = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
   logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic intFastReady = 1'b0, extFastReady = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, irqLines = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf, slowOscEn;
   logic awready, wready, bvalid, arready, rvalid, irq, modeSleep;
   logic [1:0] bresp, rresp;
   logic waitInterruptRequest, handlerReturn, sysReset_n, cpuClkEn;
   logic internalFastOscEn, externalFastOscEn, sysClkExternal, modeDeep;
   logic [15:0] periphCfgClkEn, periphRunClkEn;
   int errors = 0, cmp_count = 0, cyc = 0;

   power_mode_controller u_power_mode_controller (.clk, .reset_n,
      .coreSupplyOk, .analogSupplyOk, .awvalid, .awready, .awaddr,
      .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
      .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
      .waitInterruptRequest, .handlerReturn, .irqLines, .intFastReady,
      .extFastReady, .sysReset_n, .cpuClkEn, .internalFastOscEn,
      .externalFastOscEn, .sysClkExternal, .slowOscEn, .periphCfgClkEn,
      .periphRunClkEn, .modeSleep, .modeDeep, .irq);
   core_model u_core_model (.clk, .cpuClkEn, .waitInterruptRequest,
      .handlerReturn);

   always #5 clk = ~clk;
   // Oscillators report ready one cycle after being enabled.
   always @(posedge clk) begin
      intFastReady <= internalFastOscEn;
      extFastReady <= externalFastOscEn;
   end
   // A hang is cut short well past the expected run length.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         errors++;
         stop_test();
      end
   end

   task stop_test;
      begin
         $display("compares %0d mismatches %0d", cmp_count, errors);
         if (errors == 0 && cmp_count > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
      begin
         cmp_count++;
         if (got !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, got);
         end
      end
   endtask
   // Waits n edges, then lets that edge's updates land.
   task wt(input int n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   // Counts edges until the processor clock runs again.
   task wait_cpu(output int n);
      begin
         n = 0;
         while (cpuClkEn !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
         end
      end
   endtask
   // Address and data are released each when taken.
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad, dd;
      begin
         ad = 1'b0;
         dd = 1'b0;
         @(posedge clk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         while (!(ad && dd)) begin
            @(posedge clk);
            if (awready && !ad) begin
               awvalid <= 1'b0;
               ad = 1'b1;
            end
            if (wready && !dd) begin
               wvalid <= 1'b0;
               dd = 1'b1;
            end
         end
         do @(posedge clk); while (bvalid !== 1'b1);
         bready <= 1'b0;
         chk("bresp", {30'h0, bresp}, {30'h0, er});
         #1;
      end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      begin
         @(posedge clk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do @(posedge clk); while (arready !== 1'b1);
         arvalid <= 1'b0;
         do @(posedge clk); while (rvalid !== 1'b1);
         rready <= 1'b0;
         chk("rdata", rdata, e);
         chk("rresp", {30'h0, rresp}, {30'h0, er});
         #1;
      end
   endtask

   task t_reset;
      begin
         chk("cpuClkEn", 32'(cpuClkEn), 1);
         chk("periphCfg", 32'(periphCfgClkEn), 3);
         chk("periphRun", 32'(periphRunClkEn), 3);
         rd(`PMC_OFS_STATUS, 32'h31, OK);
         rd(`PMC_OFS_CTRL, 32'h10, OK);
         rd(`PMC_OFS_WAKEEN, 0, OK);
         $display("t_reset done");
      end
   endtask
   task t_bus;
      begin
         rd(8'h20, 0, ER);
         rd(8'h02, 0, ER);
         wr(8'h20, 32'hffff, ER);
         wr(`PMC_OFS_STATUS, 32'h0, OK);
         // Only byte lane zero may change under a partial strobe.
         wstrb <= 4'h1;
         wr(`PMC_OFS_PCFG, 32'hffff, OK);
         wstrb <= 4'hf;
         rd(`PMC_OFS_PCFG, 32'h00ff, OK);
         rd(`PMC_OFS_STATUS, 32'h31, OK);
         $display("t_bus done");
      end
   endtask
   task t_sleep;
      int n;
      begin
         wr(`PMC_OFS_WAKEEN, 32'h1, OK);
         wr(`PMC_OFS_SLOWEN, 32'h5, OK);
         u_core_model.issue(1'b0);
         wt(0);
         chk("modeSleep", 32'(modeSleep), 1);
         chk("cpuClkEn", 32'(cpuClkEn), 0);
         chk("intFastEn", 32'(internalFastOscEn), 1);
         chk("slowOscEn", 32'(slowOscEn), 5);
         irqLines <= 32'h2;
         wt(6);
         chk("modeSleep", 32'(modeSleep), 1);
         chk("irq", 32'(irq), 0);
         irqLines <= 32'h3;
         wait_cpu(n);
         chk("wakeDelay", n, 3);
         rd(`PMC_OFS_ISTAT, 32'h5, OK);
         irqLines <= 32'h0;
         wt(4);
         $display("t_sleep done");
      end
   endtask
   task t_deep;
      int n;
      begin
         wr(`PMC_OFS_IMASK, 32'h2, OK);
         wr(`PMC_OFS_CTRL, 32'h3d, OK);
         chk("sysClkExt", 32'(sysClkExternal), 1);
         u_core_model.issue(1'b0);
         wt(0);
         chk("modeDeep", 32'(modeDeep), 1);
         chk("intFastEn", 32'(internalFastOscEn), 0);
         chk("extFastEn", 32'(externalFastOscEn), 0);
         chk("slowOscEn", 32'(slowOscEn), 5);
         wt(2);
         chk("irq", 32'(irq), 1);
         irqLines <= 32'h1;
         wait_cpu(n);
         chk("settled", n, 7 + SETTLE);
         chk("sysClkExt", 32'(sysClkExternal), 0);
         rd(`PMC_OFS_CTRL, 32'h35, OK);
         rd(`PMC_OFS_ISTAT, 32'h6, OK);
         wt(2);
         chk("irq", 32'(irq), 0);
         irqLines <= 32'h0;
         wt(4);
         $display("t_deep done");
      end
   endtask
   task t_exit;
      int n;
      begin
         wr(`PMC_OFS_CTRL, 32'h12, OK);
         u_core_model.issue(1'b1);
         wt(0);
         chk("modeSleep", 32'(modeSleep), 1);
         wt(4);
         chk("modeSleep", 32'(modeSleep), 1);
         irqLines <= 32'h1;
         wait_cpu(n);
         irqLines <= 32'h0;
         wt(4);
         wr(`PMC_OFS_CTRL, 32'h10, OK);
         u_core_model.issue(1'b1);
         wt(0);
         chk("cpuClkEn", 32'(cpuClkEn), 1);
         $display("t_exit done");
      end
   endtask
   task t_supply;
      begin
         wr(`PMC_OFS_PCFG, 32'h00ff, OK);
         wr(`PMC_OFS_PRUN, 32'h0f0f, OK);
         wt(1);
         chk("periphCfg", 32'(periphCfgClkEn), 32'h00ff);
         chk("periphRun", 32'(periphRunClkEn), 32'h0f0f);
         for (int i = 0; i < 2; i++) begin
            {coreSupplyOk, analogSupplyOk} <= i ? 2'b01 : 2'b10;
            wt(2);
            chk("sysReset_n", 32'(sysReset_n), 0);
            {coreSupplyOk, analogSupplyOk} <= 2'b11;
            wt(4);
            chk("sysReset_n", 32'(sysReset_n), 1);
            rd(`PMC_OFS_PCFG, 32'h3, OK);
         end
         $display("t_supply done");
      end
   endtask

   // Main sequence: reset for twelve cycles, then each scenario.
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      wt(4);
      t_reset();
      t_bus();
      t_sleep();
      t_deep();
      t_exit();
      t_supply();
      stop_test();
   end
endmodule
`default_nettype wire
